/* File: mslr_check_monitor.sv */
`include "mslr_regs.vh"
// Watches bus timing and the trip latch of the monitor.
module mslr_check (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Motor side.
  input wire logic clk_en,
  input wire logic motor_stopped,
  input wire logic trip,
  input wire logic irq
);
  // ----------------------------------------------------------
  // Decode
  // ----------------------------------------------------------
  // A write that really lands, since a low enable drops it.
  wire logic wr_ok = psel && penable && pwrite && clk_en;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_unmapped;
    psel && !penable && !pwrite && paddr == 12'h040;
  endsequence
  sequence rd_access;
    psel && penable && clk_en;
  endsequence
  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  AST_READY: assert property (pready) else $error("pready low");
  AST_UNMAPPED: assert property (rd_unmapped ##1 rd_access |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  // A control write clears the trip one edge after it lands, so skip that edge too.
  AST_LATCH: assert property (trip && !motor_stopped && !(wr_ok && paddr == 12'h000) &&
    !$past(wr_ok && paddr == 12'h000) |=> trip)
    else $error("trip dropped");
  AST_STOP_CLR: assert property (motor_stopped && clk_en |=> !trip)
    else $error("trip held while stopped");
  AST_DISABLE: assert property (wr_ok && paddr == 12'h000 && !pwdata[0] |-> ##2 !trip)
    else $error("trip held while disabled");
  AST_FREEZE: assert property (!clk_en |=> $stable(trip) && $stable(irq))
    else $error("state moved while frozen");
  AST_MASK: assert property (wr_ok && paddr == 12'h01c && pwdata == 32'h0 |=> !irq [*2])
    else $error("masked irq high");
endmodule // mslr_check
bind mslr_monitor mslr_check u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .clk_en(clk_en), .motor_stopped(motor_stopped), .trip(trip), .irq(irq));

/* File: mslr_detect.v */
`include "mslr_regs.vh"
// Start detector: a start counts only when current passes both limits
// within the rise window after first leaving the no-load level.
module mslr_detect #(
  parameter RISE_MS = `MSLR_RISE_MS
) (
  // Clock, reset and enable.
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // Millisecond tick and method.
  input wire tick_ms,
  input wire [1:0] method,
  // Current and limits.
  input wire [15:0] current,
  input wire [15:0] noload_lim,
  input wire [15:0] detect_lim,
  // One-cycle start pulse.
  output reg start_det
);
  // ----------------------------------------------------------------
  // Rise window tracking
  // ----------------------------------------------------------------
  reg armed_r; // Motor seen stopped, waiting for a rise.
  reg rising_r; // Above no-load, window running.
  reg [7:0] win_r; // Elapsed window in milliseconds.
  wire above_nl = current > noload_lim;
  wire above_det = current > detect_lim;
  // Soft start has no fast rise, so only the two hard methods detect.
  wire hard = (method == `MSLR_METH_DIRECT) || (method == `MSLR_METH_STARDELTA);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b1;
      rising_r <= 1'b0;
      win_r <= 8'h00;
      start_det <= 1'b0;
    end else if (clk_en) begin
      start_det <= 1'b0;
      if (!above_nl) begin
        armed_r <= 1'b1;
        rising_r <= 1'b0;
        win_r <= 8'h00;
      end else if (armed_r && hard) begin
        if (above_det && win_r < RISE_MS[7:0]) begin
          start_det <= 1'b1;
          armed_r <= 1'b0;
          rising_r <= 1'b0;
        end else if (win_r >= RISE_MS[7:0]) begin
          armed_r <= 1'b0; // Slow rise is ignored.
          rising_r <= 1'b0;
        end else begin
          rising_r <= 1'b1;
          if (tick_ms) begin
            win_r <= win_r + 8'h01;
          end
        end
      end
    end
  end
endmodule // mslr_detect

/* File: mslr_monitor.v */
`include "mslr_regs.vh"
// How it works
// - Definite time or I2t principle selectable
// - I2t budget lengthens start at lower current
// - Limit from setting or hot/cold stall times
// - Accumulate I2t and compare with limit
// - Trip when start exceeds allowed value
// - Speed switch grants extra start time
// - Trip past safe stall time with switch
// - Stall mode reuses start settings after start
// - Settings for allowed time and switch use
// - Start needs both limits within 10 ms
// - Method select: direct, star-delta, soft
module mslr_monitor #(
  parameter TICK_CYC = `MSLR_TICK_CYC
) (
  // APB slave.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Clock enable.
  input wire clk_en,
  // Motor measurements and neighbours.
  input wire [15:0] phase_current,
  input wire speed_switch,
  input wire motor_stopped,
  input wire motor_stalled,
  input wire thermal_active,
  input wire [7:0] thermal_status,
  input wire [31:0] stall_time_cold,
  input wire [31:0] stall_time_hot,
  // Outputs to breaker and CPU.
  output reg trip,
  output wire irq
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [31:0] ctrl_r; // Enables, principle, source, method.
  reg [31:0] tset_r; // Allowed start time in ms.
  reg [31:0] i2t_r; // Allowed I2t level, current squared; times the allowed time gives the budget.
  reg [15:0] noload_r; // No-load current limit.
  reg [15:0] detect_r; // Start detect limit.
  reg [`MSLR_EV_W-1:0] irqs_r; // Sticky events.
  reg [`MSLR_EV_W-1:0] irqe_r; // Event enables.
  reg [31:0] elap_r; // Elapsed ms of this start or stall.
  reg [47:0] acc_r; // Accumulated I2t.
  reg active_r; // Start or stall under watch.
  reg stall_r; // Watching a stall rather than a start.
  reg ext_r; // Extension granted by the switch.
  reg [31:0] tick_r; // Millisecond prescaler.
  wire tick_ms = (tick_r == TICK_CYC - 1);
  wire wr = psel && penable && pwrite;
  wire [1:0] method = ctrl_r[`MSLR_CTRL_MTH_HI:`MSLR_CTRL_MTH_LO];
  wire start_det;
  // Zero-wait slave; unmapped addresses read zero with no error.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // ----------------------------------------------------------------
  // Start detector
  // ----------------------------------------------------------------
  mslr_detect #(
    .RISE_MS(`MSLR_RISE_MS)
  ) u_det (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .tick_ms(tick_ms),
    .method(method),
    .current(phase_current),
    .noload_lim(noload_r),
    .detect_lim(detect_r),
    .start_det(start_det)
  );
  // ----------------------------------------------------------------
  // Limit selection
  // ----------------------------------------------------------------
  // Safe stall time interpolates cold to hot with thermal status;
  // without the thermal function the manual setting is kept.
  wire use_auto = ctrl_r[`MSLR_CTRL_AUTO_BIT] && thermal_active;
  wire [39:0] hot_part = stall_time_hot * thermal_status;
  wire [39:0] cold_part = stall_time_cold * (8'hff - thermal_status);
  wire [39:0] mix = hot_part + cold_part;
  wire [31:0] safe_time = mix[39:8];
  wire [31:0] allow_time = use_auto ? safe_time : tset_r;
  wire [31:0] isq = phase_current * phase_current;
  // The I2t budget scales with the chosen time so both sources apply.
  wire [63:0] bud_full = i2t_r * allow_time;
  wire [47:0] budget = (bud_full[63:48] != 16'h0000) ? 48'hffffffffffff :
    bud_full[47:0];
  // Definite time exceeded, or I2t budget spent; lower current spends
  // the budget slower so the start may run longer.
  wire over_def = elap_r >= allow_time;
  wire over_i2t = acc_r > budget;
  wire over_main = ctrl_r[`MSLR_CTRL_I2T_BIT] ? over_i2t : over_def;
  // With the switch in use a trip needs both the main limit and the safe stall time passed.
  wire over_safe = elap_r >= safe_time;
  wire spd_on = ctrl_r[`MSLR_CTRL_SPD_BIT] && speed_switch;
  wire trip_now = active_r && ((over_main && !spd_on) ||
    (over_main && spd_on && over_safe));
  wire stall_go = ctrl_r[`MSLR_CTRL_STALL_BIT] && motor_stalled && !active_r;
  wire [47:0] acc_sum = acc_r + {16'h0000, isq};
  // ----------------------------------------------------------------
  // Monitor state
  // ----------------------------------------------------------------
  // Accumulation is once per millisecond so the budget is in ms units.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= 32'h00000000;
      elap_r <= 32'h00000000;
      acc_r <= 48'h000000000000;
      active_r <= 1'b0;
      stall_r <= 1'b0;
      ext_r <= 1'b0;
      trip <= 1'b0;
    end else if (clk_en) begin
      tick_r <= tick_ms ? 32'h00000000 : tick_r + 32'h00000001;
      if (!ctrl_r[`MSLR_CTRL_EN_BIT] || motor_stopped) begin
        active_r <= 1'b0;
        stall_r <= 1'b0;
        ext_r <= 1'b0;
        trip <= 1'b0;
      end else if (start_det || stall_go) begin
        elap_r <= 32'h00000000;
        acc_r <= 48'h000000000000;
        active_r <= 1'b1;
        stall_r <= stall_go && !start_det;
        ext_r <= 1'b0;
      end else if (active_r) begin
        if (tick_ms) begin
          elap_r <= elap_r + 32'h00000001;
          acc_r <= (acc_sum < acc_r) ? 48'hffffffffffff : acc_sum;
        end
        if (over_main && spd_on) begin
          ext_r <= 1'b1;
        end
        if (trip_now) begin
          trip <= 1'b1;
          active_r <= 1'b0;
        end else if (stall_r && !motor_stalled) begin
          active_r <= 1'b0; // Stall cleared without trip.
        end else if (!stall_r && phase_current <= detect_r && !over_main) begin
          active_r <= 1'b0; // Current fell back, start completed.
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  wire [`MSLR_EV_W-1:0] ev = {ext_r == 1'b0 && active_r && over_main && spd_on,
    trip_now, start_det || stall_go};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqs_r <= {`MSLR_EV_W{1'b0}};
    end else if (clk_en) begin
      // Set wins over a clear in the same cycle.
      irqs_r <= (irqs_r & ~((wr && paddr == `MSLR_IRQC_ADDR) ?
        pwdata[`MSLR_EV_W-1:0] : {`MSLR_EV_W{1'b0}})) | ev;
    end
  end
  assign irq = |(irqs_r & irqe_r);
  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `MSLR_CTRL_RST;
      tset_r <= `MSLR_TSET_RST;
      i2t_r <= `MSLR_I2T_RST;
      noload_r <= `MSLR_NOLOAD_RST;
      detect_r <= `MSLR_DETECT_RST;
      irqe_r <= {`MSLR_EV_W{1'b0}};
    end else if (clk_en && wr) begin
      case (paddr)
        `MSLR_CTRL_ADDR: begin
          ctrl_r <= {25'h0000000, pwdata[6:0]};
        end
        `MSLR_TSET_ADDR: begin
          tset_r <= pwdata;
        end
        `MSLR_I2T_ADDR: begin
          i2t_r <= pwdata;
        end
        `MSLR_LIM_ADDR: begin
          noload_r <= pwdata[15:0];
          detect_r <= pwdata[31:16];
        end
        `MSLR_IRQE_ADDR: begin
          irqe_r <= pwdata[`MSLR_EV_W-1:0];
        end
        default: begin
          irqe_r <= irqe_r;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Read data, registered at the setup phase
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      case (paddr)
        `MSLR_CTRL_ADDR: prdata <= ctrl_r;
        `MSLR_TSET_ADDR: prdata <= tset_r;
        `MSLR_I2T_ADDR: prdata <= i2t_r;
        `MSLR_LIM_ADDR: prdata <= {detect_r, noload_r};
        `MSLR_STAT_ADDR: prdata <= {27'h0000000, ext_r, stall_r, trip, active_r,
          speed_switch};
        `MSLR_IRQS_ADDR: prdata <= {29'h00000000, irqs_r};
        `MSLR_IRQE_ADDR: prdata <= {29'h00000000, irqe_r};
        `MSLR_ELAP_ADDR: prdata <= elap_r;
        `MSLR_ACC_ADDR: prdata <= acc_r[47:16];
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // mslr_monitor

/* File: mslr_monitor_tb.sv */
`include "mslr_regs.vh"
module mslr_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] c; logic s; logic [15:0] a; int ms; logic e;} mslr_row_t;
  localparam int TK = 10; // Cycles per millisecond tick, shortened.
  logic pclk, presetn, psel, penable, pwrite, clk_en, spin, stop, run, trip, irq, pready;
  logic thr_act, stall;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, st_c, st_h;
  logic [15:0] amp, cur;
  logic [7:0] thr_st;
  int n_errors = 0;
  int n_checks = 0;
  // Safe stall is 19 ms, allowed time 5 ms, I2t budget 5 x 40000.
  mslr_row_t rows [9] = '{
    '{32'h01, 1'b0, 16'h00c8, 8, 1'b1},
    '{32'h01, 1'b0, 16'h00c8, 3, 1'b0},
    '{32'h09, 1'b1, 16'h00c8, 10, 1'b0},
    '{32'h09, 1'b1, 16'h00c8, 25, 1'b1},
    '{32'h03, 1'b0, 16'h00c8, 8, 1'b1},
    '{32'h03, 1'b0, 16'h00a0, 6, 1'b0},
    '{32'h05, 1'b0, 16'h00c8, 10, 1'b0},
    '{32'h41, 1'b0, 16'h00c8, 8, 1'b0},
    '{32'h21, 1'b0, 16'h00c8, 8, 1'b1}};
  logic [11:0] ra [4] = '{`MSLR_CTRL_ADDR, `MSLR_TSET_ADDR, `MSLR_I2T_ADDR, `MSLR_LIM_ADDR};
  logic [31:0] rv [4] = '{`MSLR_CTRL_RST, `MSLR_TSET_RST, `MSLR_I2T_RST,
    {`MSLR_DETECT_RST, `MSLR_NOLOAD_RST}};
  mslr_monitor #(.TICK_CYC(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .clk_en(clk_en), .phase_current(cur), .speed_switch(spin),
    .motor_stopped(stop), .motor_stalled(stall), .thermal_active(thr_act),
    .thermal_status(thr_st), .stall_time_cold(st_c), .stall_time_hot(st_h), .trip(trip),
    .irq(irq));
  mslr_plant u_plant (.pclk(pclk), .presetn(presetn), .trip(trip), .run(run), .amp(amp),
    .phase_current(cur), .thermal_active(thr_act), .thermal_status(thr_st),
    .stall_time_cold(st_c), .stall_time_hot(st_h));
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  // One bus transfer; holds the request until pready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Step the current up at once and let it run.
  task automatic run_ms(input logic [31:0] c, input logic s, input logic [15:0] a, input int ms);
    apb(1'b1, `MSLR_CTRL_ADDR, c);
    spin <= s;
    stop <= 1'b0;
    run <= 1'b1;
    amp <= a;
    repeat (ms * TK) @(posedge pclk);
  endtask
  task automatic halt();
    run <= 1'b0;
    spin <= 1'b0;
    stop <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Guards against a hang; the run needs about 1400 cycles.
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, spin, run, amp, presetn} = '0;
    clk_en = 1'b1;
    stall = 1'b0;
    stop = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      check("reset value", q, rv[i]);
    end
    apb(1'b0, 12'h040, 32'h0);
    check("unmapped", q, 32'h0);
    apb(1'b1, `MSLR_TSET_ADDR, 32'h5);
    apb(1'b1, `MSLR_I2T_ADDR, 32'h9c40);
    apb(1'b1, `MSLR_IRQE_ADDR, 32'h2);
    foreach (rows[i]) begin
      run_ms(rows[i].c, rows[i].s, rows[i].a, rows[i].ms);
      check("trip", trip, rows[i].e);
      halt();
      check("trip cleared", trip, 1'b0);
    end
    // A slow rise through the detect level is not a start.
    run_ms(32'h1, 1'b0, 16'h0064, 15);
    amp <= 16'h00c8;
    repeat (8 * TK) @(posedge pclk);
    check("slow rise", trip, 1'b0);
    halt();
    // A stall with no fresh start is watched with the start settings.
    stall <= 1'b1;
    run_ms(32'h11, 1'b0, 16'h0064, 8);
    check("stall trip", trip, 1'b1);
    stall <= 1'b0;
    halt();
    // Latched trip survives loss of current and a frozen clock.
    run_ms(32'h1, 1'b0, 16'h00c8, 8);
    check("irq", irq, 1'b1);
    run <= 1'b0;
    clk_en <= 1'b0;
    repeat (30) @(posedge pclk);
    clk_en <= 1'b1;
    check("trip held", trip, 1'b1);
    apb(1'b0, `MSLR_IRQS_ADDR, 32'h0);
    check("irq status", q[1], 1'b1);
    apb(1'b1, `MSLR_IRQC_ADDR, 32'h2);
    @(posedge pclk);
    check("irq cleared", irq, 1'b0);
    apb(1'b1, `MSLR_IRQE_ADDR, 32'h0);
    apb(1'b1, `MSLR_CTRL_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    check("disabled", trip, 1'b0);
    end_of_test();
  end
endmodule // mslr_monitor_tb

/* File: mslr_plant.sv */
// Breaker, supply and thermal function around the monitor.
module mslr_plant #(
  parameter int STALL_MS = 20
) (
  // Clock, reset and breaker command.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trip,
  // Supply request from the bench.
  input wire logic run,
  input wire logic [15:0] amp,
  // Measurement and thermal data.
  output wire logic [15:0] phase_current,
  output wire logic thermal_active,
  output wire logic [7:0] thermal_status,
  output wire logic [31:0] stall_time_cold,
  output wire logic [31:0] stall_time_hot
);
  // Breaker stays open while tripped; recloses only once supply is dropped.
  logic open_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_r <= 1'b0;
    end else begin
      open_r <= trip || (open_r && run);
    end
  end
  assign phase_current = (run && !open_r) ? amp : 16'h0000;
  // Thermal function is on and reports a cold motor.
  assign thermal_active = 1'b1;
  assign thermal_status = 8'h00;
  assign stall_time_cold = 32'(STALL_MS);
  assign stall_time_hot = 32'(STALL_MS);
endmodule // mslr_plant

/* File: mslr_regs.vh */
`ifndef MSLR_REGS_VH
`define MSLR_REGS_VH
// ----------------------------------------------------------------
// Register map, byte addresses on the APB bus
// ----------------------------------------------------------------
`define MSLR_CTRL_ADDR 12'h000
`define MSLR_TSET_ADDR 12'h004
`define MSLR_I2T_ADDR 12'h008
`define MSLR_LIM_ADDR 12'h00c
`define MSLR_STAT_ADDR 12'h010
`define MSLR_IRQS_ADDR 12'h014
`define MSLR_IRQC_ADDR 12'h018
`define MSLR_IRQE_ADDR 12'h01c
`define MSLR_ELAP_ADDR 12'h020
`define MSLR_ACC_ADDR 12'h024
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define MSLR_CTRL_EN_BIT 0
`define MSLR_CTRL_I2T_BIT 1
`define MSLR_CTRL_AUTO_BIT 2
`define MSLR_CTRL_SPD_BIT 3
`define MSLR_CTRL_STALL_BIT 4
`define MSLR_CTRL_MTH_LO 5
`define MSLR_CTRL_MTH_HI 6
`define MSLR_CTRL_RST 32'h00000000
// ----------------------------------------------------------------
// Starting methods
// ----------------------------------------------------------------
`define MSLR_METH_DIRECT 2'h0
`define MSLR_METH_STARDELTA 2'h1
`define MSLR_METH_SOFT 2'h2
// ----------------------------------------------------------------
// Reset values of limits, in milliseconds and current units
// ----------------------------------------------------------------
`define MSLR_TSET_RST 32'h00002710
`define MSLR_NOLOAD_RST 16'h000a
`define MSLR_DETECT_RST 16'h0096
`define MSLR_I2T_RST 32'h00100000
// ----------------------------------------------------------------
// Timing: one millisecond tick, ten millisecond rise window
// ----------------------------------------------------------------
`define MSLR_CLK_MHZ 100
`define MSLR_TICK_US 1000
`define MSLR_TICK_CYC (`MSLR_CLK_MHZ * `MSLR_TICK_US)
`define MSLR_RISE_MS 10
// ----------------------------------------------------------------
// Status and interrupt bits
// ----------------------------------------------------------------
`define MSLR_EV_START 0
`define MSLR_EV_TRIP 1
`define MSLR_EV_EXT 2
`define MSLR_EV_W 3
`endif
